// *** design/cics_pkg.sv ***
// Constants and types shared by the two-wire control slave.
// Assumes a 125 MHz system clock; the microsecond timeout is converted to system-clock cycles.
package cics_pkg;

  // The five fixed upper bits of the seven-bit slave address.
  localparam logic [4:0] DEV_ADDR_HIGH = 5'h06;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;

  // Register indexes within a page, and the page-0 debug register's index.
  localparam logic [6:0] PAGE_REG = 7'h00;
  localparam logic [6:0] DEBUG_REG = 7'h6B;
  localparam logic [7:0] DEBUG_IDX = 8'h6B;
  localparam int DBG_STATUS_BIT = 0;
  localparam int DBG_DISABLE_BIT = 2;
  localparam logic PAGE_RESET = 1'b0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Longest time the slave may hold SDA low with SCL frozen.
  localparam int CLK_MHZ = 125;
  localparam int BUSERR_TIMEOUT_US = 10000;
  localparam int BUSERR_TIMEOUT_CYC = BUSERR_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_ACK, S_SEND, S_RACK, S_IGNORE
  } cics_state_t;

  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} cics_kind_t;

  // True for the own address with either direction, or a General Call.
  function automatic logic cics_addr_hit(input logic [7:0] b,
                                         input logic [1:0] strap);
    return (b[7:1] == {DEV_ADDR_HIGH, strap}) || (b == GEN_CALL_ADDR);
  endfunction : cics_addr_hit

endpackage : cics_pkg

// *** design/cics_link_if.sv ***
// Carrier between the line synchroniser, the core and the register file.
// All members are on clk_sys; no member crosses a clock domain.
`timescale 1ns/1ps
interface cics_link_if;
  logic sclLvl;
  logic sdaLvl;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic i2cSel;
  logic [1:0] strap;
  logic wrEn;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic errSet;
  logic errStatus;
  logic detEn;

  modport lineSrc(output sclLvl, sdaLvl, sclRise, sclFall, startEv,
                  stopEv, i2cSel, strap);
  modport core(input sclLvl, sdaLvl, sclRise, sclFall, startEv, stopEv,
               i2cSel, strap, rdata, errStatus, detEn,
               output wrEn, addr, wdata, errSet);
  modport regFile(input wrEn, addr, wdata, errSet,
                  output rdata, errStatus, detEn);
endinterface : cics_link_if

// *** design/cics_line_sync.sv ***
// Two-stage synchronisers for the bus lines and pins, plus edge events.
// Assumes SCL runs far slower than clk_sys so every edge is seen.
`timescale 1ns/1ps
module cics_line_sync
  import cics_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic protoSelect,
  input wire logic addrStrapLow,
  input wire logic addrStrapHigh,
  cics_link_if.lineSrc lnk
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [1:0] prev;
  } cics_sync_t;

  cics_sync_t q;
  cics_sync_t d;

  always_comb begin
    d = q;
    d.s1 = {addrStrapHigh, addrStrapLow, protoSelect, sdaIn, sclIn};
    d.s2 = q.s1;
    d.prev = q.s2[1:0];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= '{s1: 5'h1F, s2: 5'h1F, prev: 2'h3};
    end else if (clkEn) begin
      q <= d;
    end
  end

  // Only the second stage and its delayed copy feed the event logic.
  assign lnk.sclLvl = q.s2[0];
  assign lnk.sdaLvl = q.s2[1];
  assign lnk.sclRise = q.s2[0] & ~q.prev[0];
  assign lnk.sclFall = ~q.s2[0] & q.prev[0];
  assign lnk.startEv = q.s2[0] & q.prev[0] & q.prev[1] & ~q.s2[1];
  assign lnk.stopEv = q.s2[0] & q.prev[0] & ~q.prev[1] & q.s2[1];
  assign lnk.i2cSel = ~q.s2[2];
  assign lnk.strap = q.s2[4:3];

endmodule : cics_line_sync

// *** design/cics_reg_file.sv ***
// Two pages of 128 eight-bit registers with the page-select register.
// Assumes one write strobe at a time from the core on clk_sys.
`timescale 1ns/1ps
module cics_reg_file
  import cics_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  cics_link_if.regFile lnk
);

  typedef struct packed {
    logic [255:0][7:0] mem;
    logic page;
  } cics_regs_t;

  cics_regs_t q;
  cics_regs_t d;

  always_comb begin
    d = q;
    if (lnk.wrEn) begin
      if (lnk.addr == PAGE_REG) begin
        d.page = lnk.wdata[0];
      end else begin
        d.mem[{q.page, lnk.addr}] = lnk.wdata;
      end
      // The status bit clears by writing one; it is never stored directly.
      if (!q.page && lnk.addr == DEBUG_REG) begin
        d.mem[DEBUG_IDX][DBG_STATUS_BIT] =
          q.mem[DEBUG_IDX][DBG_STATUS_BIT] & ~lnk.wdata[DBG_STATUS_BIT];
      end
    end
    // A detector event in the clearing cycle still leaves the bit set.
    if (lnk.errSet) begin
      d.mem[DEBUG_IDX][DBG_STATUS_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= '{mem: '0, page: PAGE_RESET};
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign lnk.rdata = (lnk.addr == PAGE_REG) ? {7'h00, q.page}
                                             : q.mem[{q.page, lnk.addr}];
  assign lnk.errStatus = q.mem[DEBUG_IDX][DBG_STATUS_BIT];
  assign lnk.detEn = ~q.mem[DEBUG_IDX][DBG_DISABLE_BIT];

  a_page_select: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && lnk.wrEn && lnk.addr == PAGE_REG |=> q.page == $past(lnk.wdata[0]))
    else $error("page select not taken from written value");

  a_status_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && lnk.errSet |=> lnk.errStatus [*2])
    else $error("detector status did not set and hold");

endmodule : cics_reg_file

// *** design/cics_control_slave.sv ***
// Two-wire control slave for the codec register file.
// Assumes SCL and SDA are open-drain with external pull-ups and that the
// host keeps SCL much slower than clk_sys (fast mode or slower).
`timescale 1ns/1ps
module cics_control_slave
  import cics_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = BUSERR_TIMEOUT_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic protoSelect,
  input wire logic addrStrapLow,
  input wire logic addrStrapHigh,
  output logic sdaOut,
  output logic sdaOe,
  output logic busErrorFlag,
  output logic busy
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

  typedef struct packed {
    cics_state_t st;
    cics_kind_t kind;
    logic [3:0] bitCnt;
    logic [7:0] shreg;
    logic [6:0] ptr;
    logic rw;
    logic gc;
    logic sdaOe;
    logic sdaOut;
    logic [TW-1:0] tmo;
    logic wrEn;
    logic errPulse;
    logic errFlag;
    logic busy;
  } cics_core_t;

  cics_core_t q;
  cics_core_t d;

  cics_link_if lnk();

  cics_line_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .protoSelect(protoSelect),
    .addrStrapLow(addrStrapLow),
    .addrStrapHigh(addrStrapHigh),
    .lnk(lnk.lineSrc)
  );

  cics_reg_file u_regs (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .lnk(lnk.regFile)
  );

  // Reads and writes both use the running pointer.
  assign lnk.addr = q.ptr;
  assign lnk.wdata = q.shreg;
  assign lnk.wrEn = q.wrEn;
  assign lnk.errSet = q.errPulse;

  always_comb begin
    d = q;
    d.wrEn = 1'b0;
    d.errPulse = 1'b0;
    d.errFlag = lnk.errStatus;
    d.sdaOut = 1'b0;
    // The pointer moves one cycle after a write so the write sees it whole.
    // It wraps inside the page; the host is expected not to go past it.
    if (q.wrEn) begin
      d.ptr = q.ptr + 7'h01;
    end
    // The hold timer only runs while this slave holds SDA low.
    if (lnk.sclRise || lnk.sclFall || !q.sdaOe || !lnk.detEn) begin
      d.tmo = '0;
    end else begin
      d.tmo = q.tmo + TW'(1);
    end
    case (q.st)
      S_RECV: begin
        if (lnk.sclRise && q.bitCnt < 4'h8) begin
          d.shreg = {q.shreg[6:0], lnk.sdaLvl};
          d.bitCnt = q.bitCnt + 4'h1;
        end else if (lnk.sclFall && q.bitCnt == 4'h8) begin
          d.bitCnt = 4'h0;
          d.st = S_ACK;
          d.sdaOe = 1'b1;
          case (q.kind)
            K_ADDR: begin
              if (cics_addr_hit(q.shreg, lnk.strap)) begin
                d.rw = q.shreg[0];
                d.gc = (q.shreg == GEN_CALL_ADDR);
              end else begin
                d.st = S_IGNORE;
                d.sdaOe = 1'b0;
              end
            end
            K_PTR: begin
              if (!q.gc) begin
                d.ptr = q.shreg[6:0];
              end
            end
            default: begin
              d.wrEn = !q.gc;
            end
          endcase
        end
      end
      S_ACK: begin
        if (lnk.sclFall) begin
          d.sdaOe = 1'b0;
          d.bitCnt = 4'h0;
          if (q.kind == K_ADDR && q.rw) begin
            // Read starts at the running pointer, as left by the last pointer byte, write or read.
            d.st = S_SEND;
            d.shreg = lnk.rdata;
            d.sdaOe = ~lnk.rdata[7];
            d.ptr = q.ptr + 7'h01;
          end else begin
            d.st = S_RECV;
            d.kind = (q.kind == K_ADDR) ? K_PTR : K_DATA;
          end
        end
      end
      S_SEND: begin
        if (lnk.sclRise) begin
          d.bitCnt = q.bitCnt + 4'h1;
        end else if (lnk.sclFall) begin
          if (q.bitCnt == 4'h8) begin
            d.sdaOe = 1'b0;
            d.st = S_RACK;
          end else begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.sdaOe = ~q.shreg[6];
          end
        end
      end
      S_RACK: begin
        if (lnk.sclRise && lnk.sdaLvl) begin
          d.st = S_IGNORE;
        end else if (lnk.sclFall) begin
          d.st = S_SEND;
          d.bitCnt = 4'h0;
          d.shreg = lnk.rdata;
          d.sdaOe = ~lnk.rdata[7];
          d.ptr = q.ptr + 7'h01;
        end
      end
      default: begin
      end
    endcase
    // A master that lost clocks to noise would find SDA held forever.
    if (q.tmo == TMO_LAST) begin
      d.st = S_IGNORE;
      d.sdaOe = 1'b0;
      d.errPulse = 1'b1;
    end
    if (lnk.startEv) begin
      d.st = S_RECV;
      d.kind = K_ADDR;
      d.bitCnt = 4'h0;
      d.sdaOe = 1'b0;
      d.gc = 1'b0;
    end
    if (lnk.stopEv) begin
      d.st = S_IDLE;
      d.sdaOe = 1'b0;
    end
    if (!lnk.i2cSel) begin
      d.st = S_IDLE;
      d.sdaOe = 1'b0;
    end
    d.busy = (d.st != S_IDLE);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= '{st: S_IDLE, kind: K_ADDR, bitCnt: 4'h0, shreg: 8'h00,
             ptr: 7'h00, rw: 1'b0, gc: 1'b0, sdaOe: 1'b0, sdaOut: 1'b0,
             tmo: '0, wrEn: 1'b0, errPulse: 1'b0, errFlag: 1'b0,
             busy: 1'b0};
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign busErrorFlag = q.errFlag;
  assign busy = q.busy;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_sda_low_only: assert property (!sdaOut)
    else $error("SDA driven high");

  a_idle_released: assert property (q.st == S_IDLE |-> !sdaOe)
    else $error("SDA held while idle");

  a_change_scl_low: assert property (
    clkEn && $changed(sdaOe) && !$past(lnk.startEv) && !$past(lnk.stopEv)
    && $past(q.tmo) != TMO_LAST && $past(lnk.i2cSel) |-> !lnk.sclLvl)
    else $error("SDA changed while SCL high");

  a_stop_to_idle: assert property (clkEn && lnk.stopEv |=> q.st == S_IDLE)
    else $error("STOP did not return to idle");

  a_start_restart: assert property (
    clkEn && lnk.startEv && !lnk.stopEv && lnk.i2cSel
    |=> q.st == S_RECV && q.kind == K_ADDR && q.bitCnt == 4'h0)
    else $error("START did not restart address");

  a_addr_ack: assert property (
    clkEn && q.st == S_RECV && q.kind == K_ADDR && q.bitCnt == 4'h8 &&
    lnk.sclFall && q.shreg[7:1] == {DEV_ADDR_HIGH, lnk.strap} &&
    !lnk.startEv && !lnk.stopEv && lnk.i2cSel && q.tmo != TMO_LAST
    |=> sdaOe && q.st == S_ACK)
    else $error("own address not acknowledged");

  a_gc_ack: assert property (
    clkEn && q.st == S_RECV && q.kind == K_ADDR && q.bitCnt == 4'h8 &&
    lnk.sclFall && q.shreg == GEN_CALL_ADDR && !lnk.startEv &&
    !lnk.stopEv && lnk.i2cSel |=> sdaOe && q.gc)
    else $error("General Call not acknowledged");

  a_foreign_nack: assert property (
    clkEn && q.st == S_RECV && q.kind == K_ADDR && q.bitCnt == 4'h8 &&
    lnk.sclFall && !cics_addr_hit(q.shreg, lnk.strap)
    |=> !sdaOe [*3])
    else $error("foreign address acknowledged");

  a_write_incr: assert property (
    clkEn && q.wrEn && !lnk.startEv |=> q.ptr == $past(q.ptr) + 7'h01)
    else $error("pointer not advanced after write");

  a_nack_release: assert property (
    clkEn && q.st == S_RACK && lnk.sclRise && lnk.sdaLvl &&
    !lnk.startEv && lnk.i2cSel |=> q.st == S_IGNORE ##1 !sdaOe)
    else $error("SDA not released after read NACK");

  a_timeout_free: assert property (
    clkEn && q.tmo == TMO_LAST |=> !sdaOe && q.errPulse ##2 busErrorFlag)
    else $error("bus error not terminated");

  a_deselect_idle: assert property (clkEn && !lnk.i2cSel
    |=> q.st == S_IDLE && !busy)
    else $error("slave active while deselected");

endmodule : cics_control_slave

// *** sim/cics_host_model.sv ***
// Behavioural host master on the open-drain two-wire bus.
// Assumes each call starts just after a clk_sys rising edge.
`timescale 1ns/1ps
module cics_host_model (
  input wire logic slaveSdaOe,
  output logic sclLvl,
  output logic sdaLvl
);
  logic sclPull = 1'b0;
  logic sdaPull = 1'b0;
  int slips = 0;

  // Released lines float up to the pull-up level.
  assign sclLvl = ~sclPull;
  assign sdaLvl = ~(sdaPull | slaveSdaOe);

  task automatic start(input logic rep);
    if (rep) begin
      sclPull = 1'b1;
      #16 sdaPull = 1'b0;
      #24 sclPull = 1'b0;
      #24;
    end
    sdaPull = 1'b1;
    #24;
  endtask : start

  task automatic stop();
    sclPull = 1'b1;
    #16 sdaPull = 1'b1;
    #24 sclPull = 1'b0;
    #24 sdaPull = 1'b0;
    #40;
  endtask : stop

  // SCL low is stretched to 40 ns so the slave's late data settles first.
  task automatic bitOut(input logic b);
    sclPull = 1'b1;
    #16 sdaPull = ~b;
    #24 sclPull = 1'b0;
    #24;
  endtask : bitOut

  task automatic bitIn(output logic b);
    sclPull = 1'b1;
    #16 sdaPull = 1'b0;
    #24 sclPull = 1'b0;
    #8 b = sdaLvl;
    #16;
    if (sdaLvl !== b) slips++;
  endtask : bitIn

  task automatic wrByte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bitOut(v[i]);
    bitIn(ack);
  endtask : wrByte

  task automatic rdByte(input logic nack, output logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitIn(b);
      v[i] = b;
    end
    bitOut(nack);
  endtask : rdByte
endmodule : cics_host_model

// *** sim/cics_control_slave_tb_top.sv ***
// Self-checking bench for the two-wire control slave.
// Assumes the host model clocks the bus at 64 ns per bit.
`timescale 1ns/1ps
module cics_control_slave_tb_top
  import cics_pkg::*;
;
  localparam int TMO = 200;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic protoSelect = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] strap = 2'b00;
  logic scl;
  logic sda;
  logic sdaOut;
  logic sdaOe;
  logic busErrorFlag;
  logic busy;
  logic ack;
  logic [7:0] rd;
  int errCount = 0;
  int checks = 0;

  always #4 clk_sys = ~clk_sys;

  cics_control_slave #(.TIMEOUT_CYCLES(TMO)) uut (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .sclIn(scl),
    .sdaIn(sda), .protoSelect(protoSelect), .addrStrapLow(strap[0]),
    .addrStrapHigh(strap[1]), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .busErrorFlag(busErrorFlag), .busy(busy));

  cics_host_model host (.slaveSdaOe(sdaOe), .sclLvl(scl), .sdaLvl(sda));

  task automatic fail(input string m);
    errCount++;
    $display("Error %0t: %s", $time, m);
  endtask : fail

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask : cmp

  task automatic printVerdict();
    if (errCount == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : printVerdict

  // Looked at on the falling edge so the registered output has settled.
  always @(negedge clk_sys) begin
    if (sdaOut !== 1'b0) fail("SDA driven high");
  end

  function automatic logic [7:0] devAddr(input logic rw);
    return {DEV_ADDR_HIGH, strap, rw};
  endfunction : devAddr

  task automatic wrReg(input logic [7:0] ptr, input logic [7:0] d);
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    cmp(ack, 8'h00, "address refused");
    host.wrByte(ptr, ack);
    cmp(ack, 8'h00, "pointer refused");
    host.wrByte(d, ack);
    cmp(ack, 8'h00, "data refused");
    host.stop();
  endtask : wrReg

  task automatic rdReg(input logic [7:0] ptr, input logic [7:0] exp);
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    host.wrByte(ptr, ack);
    host.start(1'b1);
    host.wrByte(devAddr(1'b1), ack);
    cmp(ack, 8'h00, "read address refused");
    host.rdByte(1'b1, rd);
    cmp(rd, exp, "read data");
    host.stop();
  endtask : rdReg

  task automatic sProto();
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    cmp(ack, 8'h01, "answered while deselected");
    host.stop();
    protoSelect = 1'b0;
    #80;
  endtask : sProto

  task automatic sAutoInc();
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    cmp(busy, 8'h01, "idle in transfer");
    host.wrByte(8'h10, ack);
    host.wrByte(8'h5A, ack);
    host.wrByte(8'hC3, ack);
    cmp(ack, 8'h00, "second data byte refused");
    host.start(1'b1);
    host.wrByte(devAddr(1'b0), ack);
    host.wrByte(8'h10, ack);
    host.start(1'b1);
    host.wrByte(devAddr(1'b1), ack);
    cmp(ack, 8'h00, "read address refused");
    host.rdByte(1'b0, rd);
    cmp(rd, 8'h5A, "first read byte");
    host.rdByte(1'b1, rd);
    cmp(rd, 8'hC3, "second read byte");
    cmp(sdaOe, 8'h00, "SDA held after NACK");
    host.wrByte(8'h00, ack);
    cmp(ack, 8'h01, "answered after NACK");
    host.stop();
    cmp(busy, 8'h00, "busy after stop");
  endtask : sAutoInc

  task automatic sStraps();
    for (int s = 0; s < 4; s++) begin
      strap = s[1:0];
      #80;
      wrReg(8'h20, s[7:0]);
      host.start(1'b0);
      host.wrByte({DEV_ADDR_HIGH, ~strap, 1'b0}, ack);
      cmp(ack, 8'h01, "foreign address taken");
      host.stop();
    end
    rdReg(8'h20, 8'h03);
  endtask : sStraps

  task automatic sGenCall();
    host.start(1'b0);
    host.wrByte(GEN_CALL_ADDR, ack);
    cmp(ack, 8'h00, "general call refused");
    host.wrByte(8'h20, ack);
    host.wrByte(8'hEE, ack);
    host.stop();
    rdReg(8'h20, 8'h03);
  endtask : sGenCall

  task automatic sPage();
    wrReg(8'h00, 8'h01);
    rdReg(8'h00, 8'h01);
    rdReg(8'h20, 8'h00);
    wrReg(8'h20, 8'h77);
    wrReg(8'h00, 8'h00);
    rdReg(8'h20, 8'h03);
  endtask : sPage

  // With the clock enable low the slave must neither answer nor move.
  task automatic sFreeze();
    clkEn = 1'b0;
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    cmp(ack, 8'h01, "answered while frozen");
    cmp(busy, 8'h00, "moved while frozen");
    host.stop();
    clkEn = 1'b1;
    #80;
    rdReg(8'h20, 8'h03);
  endtask : sFreeze

  // SCL freezes high while the slave holds its acknowledge low.
  task automatic stall(input logic expFlag);
    host.start(1'b0);
    host.wrByte(devAddr(1'b0), ack);
    repeat (TMO + 40) @(posedge clk_sys);
    #1;
    cmp(busErrorFlag, expFlag, "detector status");
    cmp(sdaOe, !expFlag, "SDA after stall");
    host.stop();
  endtask : stall

  task automatic sBusErr();
    stall(1'b1);
    rdReg(DEBUG_IDX, 8'h01);
    wrReg(DEBUG_IDX, 8'h05);
    stall(1'b0);
  endtask : sBusErr

  initial begin
    #29;
    reset = 1'b0;
    #80;
    sProto();
    sAutoInc();
    sStraps();
    sGenCall();
    sPage();
    sFreeze();
    sBusErr();
    cmp(8'(host.slips), 8'h00, "slave data moved on SCL high");
    printVerdict();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail("run did not finish");
    printVerdict();
  end
endmodule : cics_control_slave_tb_top
